// ---- timed_queue_pkg.sv ----
package timed_queue_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Timed entry layout: flag byte, sequence tag, 16-bit time
  // ----------------------------------------------------------------
  localparam int ENTRY_BYTES = 4;
  localparam int BATCH_ENTRIES = 5;
  localparam int BATCH_BYTES = ENTRY_BYTES * BATCH_ENTRIES;
  localparam int QUEUE_DEPTH = 31;
  localparam int LEVEL0_BIT = 31;
  localparam int LEVEL1_BIT = 30;
  localparam int ENABLE0_BIT = 29;
  localparam int ENABLE1_BIT = 28;
  localparam int TAG_MSB = 23;
  localparam int TAG_LSB = 16;
  localparam int TAG_LAST_BIT = 6;
  localparam int TIME_MSB = 15;
  localparam logic [7:0] UPCOMING_MARK = 8'hc0;
  localparam int STATUS_LAST_BIT = 7;
  localparam int STATUS_ACTIVE_BIT = 1;
  localparam int STATUS_OVERFLOW_BIT = 0;

  // ----------------------------------------------------------------
  // Diagnostic record
  // ----------------------------------------------------------------
  localparam int RECORD_BYTES = 20;
  localparam int RECORD_SHORT_BYTES = 4;
  localparam logic [4:0] POS_MODULE_CLASS = 5'h01;
  localparam logic [4:0] POS_CHANNEL_KIND = 5'h04;
  localparam logic [4:0] POS_DIAG_BITS = 5'h05;
  localparam logic [4:0] POS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] POS_TICKER = 5'h10;
  localparam logic [3:0] MODULE_CLASS_DIGITAL = 4'hf;
  localparam logic [7:0] MODULE_CLASS_INFO = {3'h0, 1'b1, MODULE_CLASS_DIGITAL};
  localparam logic [7:0] CHANNEL_KIND = 8'h72;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT = 8'h02;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  typedef enum logic [1:0] {
    ACCESS_RECORD_SET,
    ACCESS_CANOPEN,
    ACCESS_ETHERCAT
  } access_kind_type;

  localparam logic [15:0] RECORD_SET_FULL = 16'h0001;
  localparam logic [15:0] RECORD_SET_SHORT = 16'h0000;
  localparam logic [15:0] CANOPEN_FULL = 16'h2f01;
  localparam logic [15:0] CANOPEN_SHORT = 16'h2f00;
  localparam logic [15:0] ETHERCAT_OBJECT = 16'h5005;
  localparam logic [7:0] SUB_FIRST = 8'h02;
  localparam logic [7:0] SUB_LAST_BYTE = 8'h11;
  localparam logic [7:0] SUB_TICKER = 8'h13;

  // ----------------------------------------------------------------
  // Controller registers (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ENTRY_PUSH = 8'h00;
  localparam logic [7:0] REG_ENTRY_FINAL = 8'h04;
  localparam logic [7:0] REG_INPUT_IMAGE = 8'h08;
  localparam logic [7:0] REG_TICKER = 8'h0c;
  localparam logic [7:0] REG_DIAG_CMD = 8'h10;
  localparam logic [7:0] REG_DIAG_DATA = 8'h14;

endpackage : timed_queue_pkg

// ---- timed_link_if.sv ----
`timescale 1ns/1ps
interface timed_link_if;
  logic entry_valid;
  logic [31:0] entry_data;
  logic [31:0] ticker;
  logic [31:0] input_image;
  logic diag_req;
  logic [1:0] diag_kind;
  logic [15:0] diag_select;
  logic [7:0] diag_sub;
  logic diag_byte_valid;
  logic [7:0] diag_byte;
  logic diag_done;
  logic diag_fault;

  modport device (
    input entry_valid, entry_data, ticker, diag_req, diag_kind, diag_select, diag_sub,
    output input_image, diag_byte_valid, diag_byte, diag_done, diag_fault
  );

  modport host (
    output entry_valid, entry_data, ticker, diag_req, diag_kind, diag_select, diag_sub,
    input input_image, diag_byte_valid, diag_byte, diag_done, diag_fault
  );
endinterface : timed_link_if

// ---- timed_output_queue_dev.sv ----
`timescale 1ns/1ps
// Function
// R1: Apply queued entries in order, then remove.
// R2: Short batch: last entry sets tag bit 6.
// R3: No interrupts; diagnostics only on request.
// R4: Record set 01h full, 00h first four.
// R5: CANopen index 2F01h full, 2F00h short.
// R6: EtherCAT object 5005h, subindex per field.
// R7: Module information byte reads 1Fh.
// R8: Channel type byte reads 72h.
// R9: Diagnostic bits per channel read 00h.
// R10: Channel count byte reads 02h.
// R11: Capture 32-bit ticker into diagnostic record.
// R12: Fixed record order, reserved bytes read zero.
// R13: Host must supply a microsecond ticker.
// R14: Written entries go straight into queue.
// R15: Drive outputs when ticker equals entry time.
// R16: Enable an output before controlling its level.
// R17: Each entry occupies four bytes.
// R18: Hold 31 entries, clear vacated slots.
// R19: Report pending count, decrement on execute.
// R20: Status bit 7 set after last-flag entry.
module timed_output_queue_dev #(
  parameter int DEPTH = timed_queue_pkg::QUEUE_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  timed_link_if.device link,
  output logic [1:0] out_level,
  output logic [1:0] out_enabled
);

  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // Queue storage
  // ----------------------------------------------------------------
  logic [31:0] slot_q [DEPTH];
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic fire;
  logic accept;
  logic [CW-1:0] write_idx;

  // The time field is 16 bits wide, so an entry whose time has already
  // passed waits for the ticker to wrap around before it executes.
  assign fire = (count_q != '0) &&
                (link.ticker[timed_queue_pkg::TIME_MSB:0] == slot_q[0][timed_queue_pkg::TIME_MSB:0]); // [R15] [R13]
  assign accept = link.entry_valid && ((count_q != CW'(DEPTH)) || fire); // [R14] [R18]
  assign write_idx = fire ? count_q - 1'b1 : count_q;

  always_comb begin
    count_d = count_q;
    if (accept && !fire) begin
      count_d = count_q + 1'b1;
    end else if (fire && !accept) begin
      count_d = count_q - 1'b1; // [R19]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Each entry shifts one place toward the head when the head fires, so
  // the head is always the oldest entry and the top slot is refilled with zero unless a full queue takes a new entry in that cycle.
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    localparam logic [CW-1:0] IDX = CW'(g);
    logic [31:0] above;
    if (g + 1 < DEPTH) begin : g_mid
      assign above = slot_q[g + 1];
    end else begin : g_top
      assign above = '0;
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        slot_q[g] <= '0;
      end else if (accept && write_idx == IDX) begin
        slot_q[g] <= link.entry_data; // [R14] [R17]
      end else if (fire) begin
        slot_q[g] <= above; // [R1] [R18]
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  logic [1:0] head_enable;
  logic [1:0] head_level;

  assign head_enable = {slot_q[0][timed_queue_pkg::ENABLE1_BIT], slot_q[0][timed_queue_pkg::ENABLE0_BIT]};
  assign head_level = {slot_q[0][timed_queue_pkg::LEVEL1_BIT], slot_q[0][timed_queue_pkg::LEVEL0_BIT]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_enabled <= 2'h0;
      out_level <= 2'h0;
    end else if (fire) begin
      out_enabled <= head_enable; // [R15]
      out_level <= head_level & head_enable; // [R15] [R16]
    end
  end

  // ----------------------------------------------------------------
  // Input image: tags, queue status, pending count
  // ----------------------------------------------------------------
  logic [7:0] last_written_tag_q;
  logic [5:0] next_tag_q;
  logic batch_closed_q;
  logic overflow_q;
  logic [7:0] upcoming_tag;
  logic [7:0] queue_status;
  logic [7:0] entry_tag;

  assign entry_tag = link.entry_data[timed_queue_pkg::TAG_MSB:timed_queue_pkg::TAG_LSB];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_written_tag_q <= 8'h00;
    end else if (accept) begin
      last_written_tag_q <= entry_tag;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      next_tag_q <= 6'h00;
    end else if (fire) begin
      next_tag_q <= slot_q[0][timed_queue_pkg::TAG_LSB +: 6] + 6'h01;
    end
  end

  // The bit stays up while the batch drains; a fresh entry without the
  // flag, written once the queue is empty, opens a new batch and drops it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      batch_closed_q <= 1'b0;
    end else if (accept && entry_tag[timed_queue_pkg::TAG_LAST_BIT]) begin
      batch_closed_q <= 1'b1; // [R20]
    end else if (accept && count_q == '0) begin
      batch_closed_q <= 1'b0;
    end
  end

  // An entry offered to a full queue that is not firing is dropped.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      overflow_q <= 1'b0;
    end else if (link.entry_valid && !accept) begin
      overflow_q <= 1'b1;
    end else if (count_q == '0) begin
      overflow_q <= 1'b0;
    end
  end

  always_comb begin
    upcoming_tag = timed_queue_pkg::UPCOMING_MARK;
    if (count_q != '0) begin
      upcoming_tag[5:0] = slot_q[0][timed_queue_pkg::TAG_LSB +: 6];
    end else begin
      upcoming_tag[5:0] = next_tag_q;
    end
    queue_status = 8'h00;
    queue_status[timed_queue_pkg::STATUS_LAST_BIT] = batch_closed_q; // [R20]
    queue_status[timed_queue_pkg::STATUS_ACTIVE_BIT] = |out_enabled;
    queue_status[timed_queue_pkg::STATUS_OVERFLOW_BIT] = overflow_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link.input_image <= '0;
    end else begin
      link.input_image <= {8'(count_q), queue_status, upcoming_tag, last_written_tag_q}; // [R19]
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic record, served only on request
  // ----------------------------------------------------------------
  typedef enum logic {
    DIAG_IDLE,
    DIAG_SEND
  } diag_state_type;

  diag_state_type diag_state_q;
  logic [31:0] ticker_snap_q;
  logic [4:0] ptr_q;
  logic [4:0] remain_q;
  logic req_ok;
  logic [4:0] req_start;
  logic [4:0] req_len;

  function automatic logic [7:0] record_byte(input logic [4:0] pos, input logic [31:0] snap);
    logic [7:0] b;
    b = timed_queue_pkg::RESERVED_BYTE; // [R12]
    case (pos)
      timed_queue_pkg::POS_MODULE_CLASS: b = timed_queue_pkg::MODULE_CLASS_INFO; // [R7]
      timed_queue_pkg::POS_CHANNEL_KIND: b = timed_queue_pkg::CHANNEL_KIND; // [R8]
      timed_queue_pkg::POS_DIAG_BITS: b = timed_queue_pkg::DIAG_BITS_PER_CHANNEL; // [R9]
      timed_queue_pkg::POS_CHANNEL_COUNT: b = timed_queue_pkg::CHANNEL_COUNT; // [R10]
      default: begin
        if (pos >= timed_queue_pkg::POS_TICKER) begin
          b = snap[8 * (pos - timed_queue_pkg::POS_TICKER) +: 8]; // [R11] [R12]
        end
      end
    endcase
    return b;
  endfunction : record_byte

  always_comb begin
    req_ok = 1'b0;
    req_start = 5'h00;
    req_len = 5'(timed_queue_pkg::RECORD_BYTES);
    case (link.diag_kind)
      timed_queue_pkg::ACCESS_RECORD_SET: begin
        req_ok = (link.diag_select == timed_queue_pkg::RECORD_SET_FULL) ||
                 (link.diag_select == timed_queue_pkg::RECORD_SET_SHORT); // [R4]
        if (link.diag_select == timed_queue_pkg::RECORD_SET_SHORT) begin
          req_len = 5'(timed_queue_pkg::RECORD_SHORT_BYTES); // [R4]
        end
      end
      timed_queue_pkg::ACCESS_CANOPEN: begin
        req_ok = (link.diag_select == timed_queue_pkg::CANOPEN_FULL) ||
                 (link.diag_select == timed_queue_pkg::CANOPEN_SHORT); // [R5]
        if (link.diag_select == timed_queue_pkg::CANOPEN_SHORT) begin
          req_len = 5'(timed_queue_pkg::RECORD_SHORT_BYTES); // [R5]
        end
      end
      timed_queue_pkg::ACCESS_ETHERCAT: begin
        if (link.diag_select == timed_queue_pkg::ETHERCAT_OBJECT) begin
          if (link.diag_sub >= timed_queue_pkg::SUB_FIRST && link.diag_sub <= timed_queue_pkg::SUB_LAST_BYTE) begin
            req_ok = 1'b1; // [R6]
            req_start = 5'(link.diag_sub - timed_queue_pkg::SUB_FIRST);
            req_len = 5'h01;
          end else if (link.diag_sub == timed_queue_pkg::SUB_TICKER) begin
            req_ok = 1'b1; // [R6]
            req_start = timed_queue_pkg::POS_TICKER;
            req_len = 5'(timed_queue_pkg::RECORD_SHORT_BYTES);
          end
        end
      end
      default: req_ok = 1'b0;
    endcase
  end

  // Requests arriving while a record is streaming are ignored. No event
  // of this block raises an interrupt; the host always has to ask.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      diag_state_q <= DIAG_IDLE;
      ticker_snap_q <= '0;
      ptr_q <= 5'h00;
      remain_q <= 5'h00;
      link.diag_byte_valid <= 1'b0;
      link.diag_byte <= 8'h00;
      link.diag_done <= 1'b0;
      link.diag_fault <= 1'b0;
    end else begin
      link.diag_byte_valid <= 1'b0;
      link.diag_done <= 1'b0;
      link.diag_fault <= 1'b0;
      case (diag_state_q)
        DIAG_IDLE: begin
          if (link.diag_req && req_ok) begin
            ticker_snap_q <= link.ticker; // [R11] [R3]
            ptr_q <= req_start;
            remain_q <= req_len;
            diag_state_q <= DIAG_SEND;
          end else if (link.diag_req) begin
            link.diag_fault <= 1'b1;
          end
        end
        DIAG_SEND: begin
          link.diag_byte_valid <= 1'b1;
          link.diag_byte <= record_byte(ptr_q, ticker_snap_q); // [R12]
          ptr_q <= ptr_q + 5'h01;
          remain_q <= remain_q - 5'h01;
          if (remain_q == 5'h01) begin
            link.diag_done <= 1'b1;
            diag_state_q <= DIAG_IDLE;
          end
        end
        default: diag_state_q <= DIAG_IDLE;
      endcase
    end
  end

endmodule : timed_output_queue_dev

// ---- timed_output_queue_host.sv ----
`timescale 1ns/1ps
module timed_output_queue_host #(
  parameter int TICK_CYCLES = timed_queue_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  timed_link_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  // ----------------------------------------------------------------
  // Microsecond ticker
  // ----------------------------------------------------------------
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic tick_en;

  assign tick_en = (div_q == $bits(div_q)'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (tick_en) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link.ticker <= '0;
    end else if (tick_en) begin
      link.ticker <= link.ticker + 32'h1; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Entry pushing
  // ----------------------------------------------------------------
  logic push;
  logic final_push;
  logic [2:0] batch_q;
  logic [1:0] enabled_q;
  logic [31:0] entry;

  assign push = wr && (addr == timed_queue_pkg::REG_ENTRY_PUSH || addr == timed_queue_pkg::REG_ENTRY_FINAL);
  assign final_push = wr && addr == timed_queue_pkg::REG_ENTRY_FINAL;

  // A level request for an output that the previous entry left disabled
  // would be lost, so the enable bit is added to the same entry.
  always_comb begin
    entry = wdata;
    if (wdata[timed_queue_pkg::LEVEL0_BIT] && !enabled_q[0]) begin
      entry[timed_queue_pkg::ENABLE0_BIT] = 1'b1; // [R16]
    end
    if (wdata[timed_queue_pkg::LEVEL1_BIT] && !enabled_q[1]) begin
      entry[timed_queue_pkg::ENABLE1_BIT] = 1'b1; // [R16]
    end
    if (final_push && batch_q < 3'(timed_queue_pkg::BATCH_ENTRIES - 1)) begin
      entry[timed_queue_pkg::TAG_LSB + timed_queue_pkg::TAG_LAST_BIT] = 1'b1; // [R2]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      batch_q <= 3'h0;
      enabled_q <= 2'h0;
      link.entry_valid <= 1'b0;
      link.entry_data <= '0;
    end else begin
      link.entry_valid <= push; // [R17]
      if (push) begin
        link.entry_data <= entry;
        enabled_q <= {entry[timed_queue_pkg::ENABLE1_BIT], entry[timed_queue_pkg::ENABLE0_BIT]};
        batch_q <= final_push ? 3'h0 : batch_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic requests and record capture
  // ----------------------------------------------------------------
  logic [7:0] diag_buf_q [timed_queue_pkg::RECORD_BYTES];
  logic [4:0] diag_cnt_q;
  logic diag_busy_q;
  logic diag_fault_q;
  logic diag_cmd;

  assign diag_cmd = wr && addr == timed_queue_pkg::REG_DIAG_CMD && !diag_busy_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link.diag_req <= 1'b0;
      link.diag_kind <= 2'h0;
      link.diag_select <= 16'h0000;
      link.diag_sub <= 8'h00;
      diag_busy_q <= 1'b0;
      diag_fault_q <= 1'b0;
      diag_cnt_q <= 5'h00;
    end else begin
      link.diag_req <= diag_cmd; // [R4] [R5] [R6]
      if (diag_cmd) begin
        link.diag_kind <= wdata[1:0];
        link.diag_sub <= wdata[15:8];
        link.diag_select <= wdata[31:16];
        diag_busy_q <= 1'b1;
        diag_fault_q <= 1'b0;
        diag_cnt_q <= 5'h00;
      end else if (link.diag_done || link.diag_fault) begin
        diag_busy_q <= 1'b0;
        diag_fault_q <= link.diag_fault;
      end
      if (link.diag_byte_valid) begin
        diag_cnt_q <= diag_cnt_q + 5'h01;
      end
    end
  end

  for (genvar g = 0; g < timed_queue_pkg::RECORD_BYTES; g++) begin : g_buf
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        diag_buf_q[g] <= 8'h00;
      end else if (link.diag_byte_valid && diag_cnt_q == 5'(g)) begin
        diag_buf_q[g] <= link.diag_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [7:0] word_off;

  assign word_off = addr - timed_queue_pkg::REG_DIAG_DATA;

  always_comb begin
    rd_mux = '0;
    case (addr)
      timed_queue_pkg::REG_INPUT_IMAGE: rd_mux = link.input_image; // [R19] [R20]
      timed_queue_pkg::REG_TICKER: rd_mux = link.ticker;
      timed_queue_pkg::REG_DIAG_CMD: rd_mux = {19'h0, diag_cnt_q, 6'h0, diag_fault_q, diag_busy_q};
      default: begin
        if (addr >= timed_queue_pkg::REG_DIAG_DATA && word_off < 8'(timed_queue_pkg::RECORD_BYTES)
            && addr[1:0] == 2'h0) begin
          rd_mux = {diag_buf_q[word_off[4:0] + 5'h3], diag_buf_q[word_off[4:0] + 5'h2],
                    diag_buf_q[word_off[4:0] + 5'h1], diag_buf_q[word_off[4:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= '0;
    end
  end

endmodule : timed_output_queue_host

// ---- timed_link_props.sv ----
`timescale 1ns/1ps
module timed_link_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic entry_valid,
  input wire logic [31:0] entry_data,
  input wire logic [31:0] input_image,
  input wire logic diag_req,
  input wire logic [1:0] diag_kind,
  input wire logic [15:0] diag_select,
  input wire logic [7:0] diag_sub,
  input wire logic diag_byte_valid,
  input wire logic [7:0] diag_byte,
  input wire logic diag_done,
  input wire logic diag_fault
);
  // ----------------------------------------
  // Request tracking
  // ----------------------------------------
  logic busy_q;
  logic [4:0] idx_q;
  logic start;
  logic full_rec;
  logic short_rec;
  assign start = diag_req && !busy_q;
  assign full_rec = (diag_kind == 2'h0 && diag_select == 16'h0001) || (diag_kind == 2'h1 && diag_select == 16'h2f01);
  assign short_rec = (diag_kind == 2'h0 && diag_select == 16'h0000) || (diag_kind == 2'h1 && diag_select == 16'h2f00);
  always_ff @(posedge core_clk) begin
    if (!rst_n || diag_done || diag_fault) busy_q <= 1'b0;
    else if (diag_req) busy_q <= 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n || start) idx_q <= 5'h00;
    else if (diag_byte_valid) idx_q <= idx_q + 5'h01;
  end
  function automatic logic [7:0] rec_byte(input logic [4:0] i);
    case (i)
      5'h01: rec_byte = 8'h1f;
      5'h04: rec_byte = 8'h72;
      5'h06: rec_byte = 8'h02;
      default: rec_byte = 8'h00;
    endcase
  endfunction : rec_byte
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_last_tag;
    (entry_valid && input_image[31:24] < 8'h1d) ##1 !entry_valid |=> input_image[7:0] == $past(entry_data[23:16], 2);
  endproperty
  a_last_tag: assert property (p_last_tag) else $error("last tag not shown");
  property p_last_flag;
    (entry_valid && entry_data[22] && input_image[31:24] < 8'h1d) |-> ##2 input_image[23];
  endproperty
  a_last_flag: assert property (p_last_flag) else $error("last flag status missing");
  property p_count_step;
    input_image[31:24] != $past(input_image[31:24]) |->
      (input_image[31:24] - $past(input_image[31:24]) == 8'h01) || ($past(input_image[31:24]) - input_image[31:24] == 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("pending count jumped");
  property p_diag_start;
    start |-> ##[1:2] (diag_byte_valid || diag_fault);
  endproperty
  a_diag_start: assert property (p_diag_start) else $error("diag request unanswered");
  property p_on_request;
    diag_byte_valid |-> busy_q;
  endproperty
  a_on_request: assert property (p_on_request) else $error("diag byte without request");
  property p_record_bytes;
    (diag_byte_valid && (full_rec || short_rec) && idx_q < 5'h10) |-> diag_byte == rec_byte(idx_q);
  endproperty
  a_record_bytes: assert property (p_record_bytes) else $error("record byte wrong");
  property p_full_len;
    (diag_done && full_rec) |-> diag_byte_valid && idx_q == 5'h13;
  endproperty
  a_full_len: assert property (p_full_len) else $error("full record length wrong");
  property p_short_len;
    (diag_done && short_rec) |-> diag_byte_valid && idx_q == 5'h03;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short record length wrong");
  property p_ecat_sub;
    (start && diag_kind == 2'h2 && diag_sub == 8'h06) |-> ##2 diag_byte_valid && diag_done && diag_byte == 8'h72;
  endproperty
  a_ecat_sub: assert property (p_ecat_sub) else $error("subindex byte wrong");
  property p_bad_sub;
    (start && diag_kind == 2'h2 && diag_sub == 8'h12) |-> ##1 diag_fault;
  endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("bad subindex not refused");
endmodule : timed_link_props

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] out_level;
  logic [1:0] out_enabled;
  int error_cnt = 0;
  int n_checks = 0;
  timed_link_if link ();
  always #20 core_clk = ~core_clk;
  // A short tick keeps the queue waits at two clocks per microsecond.
  timed_output_queue_host #(.TICK_CYCLES(2)) timed_output_queue_host_inst (.core_clk(core_clk), .rst_n(rst_n),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  timed_output_queue_dev timed_output_queue_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .out_level(out_level), .out_enabled(out_enabled));
  timed_link_props timed_link_props_inst (.core_clk(core_clk), .rst_n(rst_n), .entry_valid(link.entry_valid),
    .entry_data(link.entry_data), .input_image(link.input_image), .diag_req(link.diag_req),
    .diag_kind(link.diag_kind), .diag_select(link.diag_select), .diag_sub(link.diag_sub),
    .diag_byte_valid(link.diag_byte_valid), .diag_byte(link.diag_byte), .diag_done(link.diag_done),
    .diag_fault(link.diag_fault));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_us(input logic [31:0] t);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      rd_reg(timed_queue_pkg::REG_TICKER, v);
      if (v >= t) break;
    end
  endtask : wait_us
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    logic [31:0] v;
    rd_reg(timed_queue_pkg::REG_INPUT_IMAGE, v);
    chk(v & 32'hffff0000, 32'h0);
    rd_reg(8'hfc, v);
    chk(v, 32'h0);
  endtask : test_reset
  task automatic test_queue;
    logic [31:0] t0;
    logic [31:0] v;
    rd_reg(timed_queue_pkg::REG_TICKER, t0);
    wr_reg(timed_queue_pkg::REG_ENTRY_PUSH, {8'h80, 8'h01, t0[15:0] + 16'h0028});
    wr_reg(timed_queue_pkg::REG_ENTRY_PUSH, {8'hb0, 8'h02, t0[15:0] + 16'h003c});
    wr_reg(timed_queue_pkg::REG_ENTRY_FINAL, {8'h70, 8'h03, t0[15:0] + 16'h0050});
    repeat (2) @(posedge core_clk);
    rd_reg(timed_queue_pkg::REG_INPUT_IMAGE, v);
    chk({v[31:23], v[15:0]}, {8'h03, 1'b1, 8'hc1, 8'h43});
    wait_us(t0 + 32'h2a);
    chk({out_enabled, out_level}, 4'h5);
    wait_us(t0 + 32'h3e);
    rd_reg(timed_queue_pkg::REG_INPUT_IMAGE, v);
    chk({v[31:24], out_level}, {8'h01, 2'b01});
    wait_us(t0 + 32'h52);
    rd_reg(timed_queue_pkg::REG_INPUT_IMAGE, v);
    chk({v[31:23], out_level}, {8'h00, 1'b1, 2'b10});
  endtask : test_queue
  task automatic diag(input logic [1:0] kind, input logic [15:0] sel, input logic [7:0] sub, input logic [4:0] n,
                      input logic [31:0] w0, input logic [31:0] w1);
    logic [31:0] t_a;
    logic [31:0] t_b;
    logic [31:0] v;
    rd_reg(timed_queue_pkg::REG_TICKER, t_a);
    wr_reg(timed_queue_pkg::REG_DIAG_CMD, {sel, sub, 6'h00, kind});
    for (int i = 0; i < 100; i++) begin
      rd_reg(timed_queue_pkg::REG_DIAG_CMD, v);
      if (v[0] === 1'b0) break;
    end
    rd_reg(timed_queue_pkg::REG_TICKER, t_b);
    chk({v[12:8], v[1:0]}, {n, n == 5'h00, 1'b0});
    if (n != 5'h00) begin
      rd_reg(timed_queue_pkg::REG_DIAG_DATA, v);
      if (n == 5'h01) v = v & 32'h000000ff;
      if (sub == 8'h13) chk(v >= t_a && v <= t_b, 1'b1);
      else chk(v, w0);
    end
    if (n == 5'h14) begin
      rd_reg(8'h18, v);
      chk(v, w1);
      rd_reg(8'h1c, v);
      chk(v, 32'h0);
      rd_reg(8'h20, v);
      chk(v, 32'h0);
      rd_reg(8'h24, v);
      chk(v >= t_a && v <= t_b, 1'b1);
    end
  endtask : diag
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    test_reset();
    test_queue();
    diag(2'h0, 16'h0001, 8'h00, 5'h14, 32'h00001f00, 32'h00020072);
    diag(2'h0, 16'h0000, 8'h00, 5'h04, 32'h00001f00, 32'h0);
    diag(2'h1, 16'h2f01, 8'h00, 5'h14, 32'h00001f00, 32'h00020072);
    diag(2'h1, 16'h2f00, 8'h00, 5'h04, 32'h00001f00, 32'h0);
    diag(2'h2, 16'h5005, 8'h03, 5'h01, 32'h0000001f, 32'h0);
    diag(2'h2, 16'h5005, 8'h06, 5'h01, 32'h00000072, 32'h0);
    diag(2'h2, 16'h5005, 8'h07, 5'h01, 32'h00000000, 32'h0);
    diag(2'h2, 16'h5005, 8'h08, 5'h01, 32'h00000002, 32'h0);
    diag(2'h2, 16'h5005, 8'h13, 5'h04, 32'h0, 32'h0);
    diag(2'h2, 16'h5005, 8'h12, 5'h00, 32'h0, 32'h0);
    give_verdict();
  end
endmodule : tb_top
